/* src/spcbg_defs.vh */
// constants for the serial port control and baud generation block
`ifndef SPCBG_DEFS_VH
`define SPCBG_DEFS_VH
// apb byte addresses
`define SPCBG_ADDR_CTRL     12'h000
`define SPCBG_ADDR_BUF      12'h004
`define SPCBG_ADDR_RATE     12'h008
`define SPCBG_ADDR_T1RLD    12'h00C
`define SPCBG_ADDR_T2CTRL   12'h010
`define SPCBG_ADDR_T2RLD    12'h014
`define SPCBG_ADDR_T2CNT    12'h018
// serial_control fields
`define SPCBG_B_MODE_HI     7
`define SPCBG_B_MODE_LO     6
`define SPCBG_B_MP_EN       5
`define SPCBG_B_RX_EN       4
`define SPCBG_B_TX9         3
`define SPCBG_B_RX9         2
`define SPCBG_B_TX_DONE     1
`define SPCBG_B_RX_DONE     0
// timer2_control fields
`define SPCBG_B_T2_RXCLK    5
`define SPCBG_B_T2_TXCLK    4
`define SPCBG_B_T2_EXEN     3
`define SPCBG_B_T2_RUN      2
`define SPCBG_B_T2_EXF      1
`define SPCBG_B_T2_OVF      0
// reset values
`define SPCBG_CTRL_RESET    8'h00
`define SPCBG_T1RLD_RESET   8'h00
`define SPCBG_T2RLD_RESET   16'h0000
// dividers (oscillator clocks)
`define SPCBG_DIV_MODE0     12
`define SPCBG_DIV_MODE2     64
`define SPCBG_DIV_T1_PRE    12
`define SPCBG_DIV_T1_OVF    32
`define SPCBG_DIV_T2_PRE    2
`define SPCBG_DIV_T2_OVF    16
`define SPCBG_SAMPLE_DIV    16
`endif

/* src/spcbg_serial_port.v */
// serial port control, frame engine and baud generation with apb registers
// Function
// - mode bits pick shift or uart modes
// - modes 2/3 multiproc drops ninth-bit-zero frames
// - mode 1 multiproc needs valid stop bit
// - receive enable gates reception
// - modes 2/3 send software ninth bit
// - received ninth bit or stop captured
// - transmit flag set by hardware, software clears
// - receive flag set by hardware, software clears
// - mode 2 rate osc/64 or osc/32
// - timer1 rate times doubling over 32
// - timer2 clock selects enter baud mode
// - port1 selects live in timer2 control
// - timer2 rollover reloads from preset pair
// - timer2 source rate is overflow/16
// - baud rollover sets no overflow flag
// - external pin fall sets flag, no reload
// - mode 0 shifts lsb first, clock pin
// - buffer write starts sending, marker bit
// - mode 0 one machine cycle before shifting
// - frames ten or eleven bits
// - reception start conditions per mode
// - separate receive and transmit buffers
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "spcbg_defs.vh"
module spcbg_serial_port #(
  parameter MC_DIV = `SPCBG_DIV_MODE0  // oscillator clocks per machine cycle
) (
  input  wire        core_clk,      // system oscillator clock
  input  wire        rst,           // async reset, active high
  input  wire        psel,          // apb select
  input  wire        penable,       // apb enable
  input  wire        pwrite,        // apb direction
  input  wire [11:0] paddr,         // apb byte address
  input  wire [31:0] pwdata,        // apb write data
  output reg  [31:0] prdata,        // apb read data
  output reg         pready,        // apb ready
  output reg         pslverr,       // apb error, unmapped address
  input  wire        rxd_in,        // data pin input
  output reg         rxd_out,       // data pin output (mode 0)
  output reg         rxd_oe_n,      // data pin enable, low drives
  output reg         txd_out,       // uart tx or mode 0 shift clock
  input  wire        timer2_external_pin, // timer2 external input
  output reg         serial_irq,    // serial port interrupt request
  output reg         timer2_irq     // timer2 request, external or overflow flag
);
  localparam TX_IDLE = 2'd0;
  localparam TX_WAIT = 2'd1;
  localparam TX_RUN  = 2'd2;
  localparam RX_IDLE = 2'd0;
  localparam RX_M0   = 2'd1;
  localparam RX_RUN  = 2'd2;

  reg  [7:0]  ctrl_q;        // serial_control
  reg         rate_double_q;
  reg  [7:0]  t1_reload_q;   // timer1_reload_byte
  reg  [7:0]  t1_cnt_q;
  reg  [3:0]  t1_pre_q;
  reg  [5:0]  t2_ctrl_q;     // timer2_control
  reg  [15:0] t2_reload_q;   // timer2_reload_high/low
  reg  [15:0] t2_cnt_q;      // timer2_count_high/low
  reg         t2_pre_q;
  reg         timer2_external_pin_q;
  reg  [7:0]  rx_buf_q;      // serial_buffer read side
  reg  [3:0]  mc_q;          // machine cycle phase
  reg  [5:0]  m2_q;          // mode 2 divider
  reg  [4:0]  t1_div_q;
  reg  [3:0]  tx16_q;
  reg  [3:0]  rx16_q;
  reg  [1:0]  tx_st_q;
  reg  [10:0] tx_sh_q;
  reg  [3:0]  tx_bits_q;
  reg         tx_pend_q;
  reg  [1:0]  rx_st_q;
  reg  [8:0]  rx_sh_q;
  reg  [3:0]  rx_bits_q;
  reg  [2:0]  rx_smp_q;
  reg         rxd_q;

  wire [1:0] mode = {ctrl_q[`SPCBG_B_MODE_HI], ctrl_q[`SPCBG_B_MODE_LO]};
  wire       t2_baud = t2_ctrl_q[`SPCBG_B_T2_RXCLK] | t2_ctrl_q[`SPCBG_B_T2_TXCLK];
  wire       wr = psel & penable & pwrite;
  wire       rd = psel & penable & ~pwrite;
  wire       mc_tick = (mc_q == MC_DIV - 1);
  // mode 2 clock, osc/4 or osc/2, fed to the 16x bit counter
  wire       m2_tick = rate_double_q ? (m2_q[0]) : (m2_q[1:0] == 2'h3);
  // x16 tick every second overflow, every overflow when doubled (bit = 32 or 16)
  wire       t1_ovf = t1_pre_q == `SPCBG_DIV_T1_PRE - 1 && t1_cnt_q == 8'hFF;
  wire       t1_tick = t1_ovf && (rate_double_q || t1_div_q[0]);
  // timer2 counts at osc/2, overflow feeds the 16x counter
  wire       t2_inc = t2_ctrl_q[`SPCBG_B_T2_RUN] & t2_pre_q;
  wire       t2_ovf = t2_baud & t2_inc & (t2_cnt_q == 16'hFFFF);
  wire       var_tx = t2_ctrl_q[`SPCBG_B_T2_TXCLK] ? t2_ovf : t1_tick;
  wire       var_rx = t2_ctrl_q[`SPCBG_B_T2_RXCLK] ? t2_ovf : t1_tick;
  wire       tx_x16 = (mode == 2'd2) ? m2_tick : var_tx;
  wire       rx_x16 = (mode == 2'd2) ? m2_tick : var_rx;
  wire       tx_bit = tx_x16 && tx16_q == 4'hF;
  wire       timer2_external_pin_fall = timer2_external_pin_q & ~timer2_external_pin;

  // decode of register addresses, used for read and write
  function hit;
    input [11:0] a;
    begin
      if (a == `SPCBG_ADDR_CTRL) hit = 1'b1;
      else if (a == `SPCBG_ADDR_BUF) hit = 1'b1;
      else if (a == `SPCBG_ADDR_RATE) hit = 1'b1;
      else if (a == `SPCBG_ADDR_T1RLD) hit = 1'b1;
      else if (a == `SPCBG_ADDR_T2CTRL) hit = 1'b1;
      else if (a == `SPCBG_ADDR_T2RLD) hit = 1'b1;
      else if (a == `SPCBG_ADDR_T2CNT) hit = 1'b1;
      else hit = 1'b0;
    end
  endfunction

  // apb slave: one wait state, answer on second access cycle
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit(paddr);
      if (psel & penable & ~pready & ~pwrite) begin
        if (paddr == `SPCBG_ADDR_CTRL) prdata <= {24'h000000, ctrl_q};
        else if (paddr == `SPCBG_ADDR_BUF) prdata <= {24'h000000, rx_buf_q};
        else if (paddr == `SPCBG_ADDR_RATE) prdata <= {31'h00000000, rate_double_q};
        else if (paddr == `SPCBG_ADDR_T1RLD) prdata <= {24'h000000, t1_reload_q};
        else if (paddr == `SPCBG_ADDR_T2CTRL) prdata <= {26'h0000000, t2_ctrl_q};
        else if (paddr == `SPCBG_ADDR_T2RLD) prdata <= {16'h0000, t2_reload_q};
        else if (paddr == `SPCBG_ADDR_T2CNT) prdata <= {16'h0000, t2_cnt_q};
        else prdata <= 32'h00000000;
      end
    end
  end

  wire acc    = wr & pready;   // write takes effect on completing edge
  wire wr_buf = acc && paddr == `SPCBG_ADDR_BUF;
  wire wr_ctl = acc && paddr == `SPCBG_ADDR_CTRL;
  wire unused_rd = rd;

  // frame-complete events
  reg tx_done_set;
  reg rx_done_set;
  reg rx_load;
  reg [7:0] rx_byte;
  reg rx9_val;

  // dividers and timers
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mc_q <= 4'h0;
      m2_q <= 6'h00;
      t1_pre_q <= 4'h0;
      t1_cnt_q <= 8'h00;
      t1_div_q <= 5'h00;
      t2_pre_q <= 1'b0;
      t2_cnt_q <= 16'h0000;
      timer2_external_pin_q <= 1'b1;
    end else begin
      mc_q <= mc_tick ? 4'h0 : mc_q + 4'h1;
      m2_q <= m2_q + 6'h01;
      timer2_external_pin_q <= timer2_external_pin;
      // timer1 modelled as 8-bit auto-reload at osc/12
      t1_pre_q <= (t1_pre_q == `SPCBG_DIV_T1_PRE - 1) ? 4'h0 : t1_pre_q + 4'h1;
      if (t1_pre_q == `SPCBG_DIV_T1_PRE - 1) begin
        t1_cnt_q <= (t1_cnt_q == 8'hFF) ? t1_reload_q : t1_cnt_q + 8'h01;
      end
      if (t1_ovf) t1_div_q <= t1_div_q + 5'h01;
      t2_pre_q <= ~t2_pre_q;
      if (acc && paddr == `SPCBG_ADDR_T2CNT) t2_cnt_q <= pwdata[15:0];
      else if (t2_inc) t2_cnt_q <= (t2_cnt_q == 16'hFFFF) ? t2_reload_q : t2_cnt_q + 16'h0001;
    end
  end

  // software registers and flags; hardware set wins over clear
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `SPCBG_CTRL_RESET;
      rate_double_q <= 1'b0;
      t1_reload_q <= `SPCBG_T1RLD_RESET;
      t2_reload_q <= `SPCBG_T2RLD_RESET;
      t2_ctrl_q <= 6'h00;
      rx_buf_q <= 8'h00;
    end else begin
      if (wr_ctl) ctrl_q <= pwdata[7:0];
      if (acc && paddr == `SPCBG_ADDR_RATE) rate_double_q <= pwdata[0];
      if (acc && paddr == `SPCBG_ADDR_T1RLD) t1_reload_q <= pwdata[7:0];
      if (acc && paddr == `SPCBG_ADDR_T2RLD) t2_reload_q <= pwdata[15:0];
      if (acc && paddr == `SPCBG_ADDR_T2CTRL) t2_ctrl_q <= pwdata[5:0];
      if (tx_done_set) ctrl_q[`SPCBG_B_TX_DONE] <= 1'b1;
      if (rx_done_set) ctrl_q[`SPCBG_B_RX_DONE] <= 1'b1;
      if (rx_load) begin
        rx_buf_q <= rx_byte;
        if (mode != 2'd0) ctrl_q[`SPCBG_B_RX9] <= rx9_val;
      end
      // external fall sets flag only when enabled, never reloads
      if (timer2_external_pin_fall & t2_ctrl_q[`SPCBG_B_T2_EXEN]) t2_ctrl_q[`SPCBG_B_T2_EXF] <= 1'b1;
      // the overflow flag is never set by a baud rollover
    end
  end

  // transmitter: mode 0 shift clock or uart frame
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_st_q <= TX_IDLE;
      tx_sh_q <= 11'h7FF;
      tx_bits_q <= 4'h0;
      tx_pend_q <= 1'b0;
      tx16_q <= 4'h0;
      txd_out <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe_n <= 1'b1;
    end else begin
      if (tx_x16) tx16_q <= tx16_q + 4'h1;
      case (tx_st_q)
        TX_IDLE: begin
          // shift clock also runs while mode 0 receives, left high at the end
          txd_out <= (rx_st_q != RX_M0) || (mc_tick && rx_bits_q == 4'h1) ||
                     ((mc_q >= MC_DIV / 2 - 1) && !mc_tick);
          if (wr_buf) begin
            if (mode == 2'd0) begin
              tx_sh_q <= {2'b00, 1'b1, pwdata[7:0]}; // end marker in ninth place
              tx_pend_q <= 1'b0;
              tx_st_q <= TX_WAIT;
            end else begin
              // start, data lsb first, ninth bit (modes 2/3), stop
              tx_sh_q <= (mode == 2'd1) ? {2'b11, pwdata[7:0], 1'b0}
                                        : {1'b1, ctrl_q[`SPCBG_B_TX9], pwdata[7:0], 1'b0};
              tx_bits_q <= (mode == 2'd1) ? 4'd10 : 4'd11;
              tx_pend_q <= 1'b1;
              tx_st_q <= TX_RUN;
            end
          end
        end
        TX_WAIT: begin
          // first boundary arms, shifting starts one whole machine cycle later
          if (mc_tick && !tx_pend_q) begin
            tx_pend_q <= 1'b1;
          end else if (mc_tick) begin
            tx_pend_q <= 1'b0;
            tx_st_q <= TX_RUN;
            tx_bits_q <= 4'd8;
            rxd_oe_n <= 1'b0;
            rxd_out <= tx_sh_q[0];
          end
        end
        TX_RUN: begin
          if (mode == 2'd0) begin
            // clock low first half, high second half of machine cycle
            txd_out <= (mc_q >= MC_DIV / 2 - 1) && !mc_tick;
            if (mc_tick) begin
              tx_sh_q <= {1'b0, tx_sh_q[10:1]};
              tx_bits_q <= tx_bits_q - 4'h1;
              rxd_out <= tx_sh_q[1];
              if (tx_bits_q == 4'h1) begin
                tx_st_q <= TX_IDLE; // end of eighth bit
                rxd_oe_n <= 1'b1;
                txd_out <= 1'b1;
              end
            end
          end else if (tx_bit) begin
            if (tx_pend_q) begin
              tx_pend_q <= 1'b0;
              txd_out <= tx_sh_q[0];
            end else begin
              tx_sh_q <= {1'b1, tx_sh_q[10:1]};
              txd_out <= tx_sh_q[1];
              tx_bits_q <= tx_bits_q - 4'h1;
              if (tx_bits_q == 4'h2) tx_st_q <= TX_IDLE; // stop bit now on line
            end
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // transmit flag: eighth bit end (mode 0) or stop bit start
  always @* begin
    tx_done_set = 1'b0;
    if (tx_st_q == TX_RUN) begin
      if (mode == 2'd0) tx_done_set = mc_tick && tx_bits_q == 4'h1;
      else tx_done_set = tx_bit && !tx_pend_q && tx_bits_q == 4'h2;
    end
  end

  // receiver with 16x sampling and majority vote
  wire vote = (rx_smp_q[0] & rx_smp_q[1]) | (rx_smp_q[1] & rx_smp_q[2]) |
              (rx_smp_q[0] & rx_smp_q[2]);
  wire rx_en = ctrl_q[`SPCBG_B_RX_EN];
  wire last_uart = rx_bits_q == 4'h1;
  wire rx_bit_end = rx_x16 && rx16_q == 4'h9;

  always @* begin
    rx_done_set = 1'b0;
    rx_load = 1'b0;
    rx_byte = rx_sh_q[7:0];
    rx9_val = vote;
    if (rx_st_q == RX_M0 && mc_tick && rx_bits_q == 4'h1) begin
      rx_load = 1'b1; // eighth bit end
      rx_done_set = 1'b1;
      rx_byte = {rxd_in, rx_sh_q[7:1]};
    end else if (rx_st_q == RX_RUN && rx_bit_end && last_uart) begin
      // filter by multiproc enable; rx9 is ninth bit or stop
      rx_byte = (mode == 2'd1) ? rx_sh_q[8:1] : rx_sh_q[7:0];
      rx9_val = (mode == 2'd1) ? vote : rx_sh_q[8];
      if (!ctrl_q[`SPCBG_B_RX_DONE] && (!ctrl_q[`SPCBG_B_MP_EN] || rx9_val)) begin
        rx_load = 1'b1;
        rx_done_set = 1'b1; // mid stop bit
      end
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_st_q <= RX_IDLE;
      rx_sh_q <= 9'h000;
      rx_bits_q <= 4'h0;
      rx_smp_q <= 3'h7;
      rx16_q <= 4'h0;
      rxd_q <= 1'b1;
    end else begin
      rxd_q <= rxd_in;
      if (rx_x16) rx16_q <= rx16_q + 4'h1;
      if (rx_x16 && rx16_q >= 4'h6 && rx16_q <= 4'h8) rx_smp_q <= {rx_smp_q[1:0], rxd_in};
      case (rx_st_q)
        RX_IDLE: begin
          // mode 0 needs flag clear; uarts wait for a start edge
          if (rx_en && mode == 2'd0 && !ctrl_q[`SPCBG_B_RX_DONE] && mc_tick) begin
            rx_st_q <= RX_M0;
            rx_bits_q <= 4'd8;
          end else if (rx_en && mode != 2'd0 && rxd_q && !rxd_in) begin
            rx_st_q <= RX_RUN;
            rx16_q <= 4'h0;
            rx_bits_q <= (mode == 2'd1) ? 4'd10 : 4'd11;
          end
        end
        RX_M0: begin
          if (mc_tick) begin
            rx_sh_q <= {1'b0, rxd_in, rx_sh_q[7:1]}; // lsb first
            rx_bits_q <= rx_bits_q - 4'h1;
            if (rx_bits_q == 4'h1) rx_st_q <= RX_IDLE;
          end
        end
        RX_RUN: begin
          if (!rx_en) rx_st_q <= RX_IDLE;
          else if (rx_bit_end) begin
            rx_bits_q <= rx_bits_q - 4'h1;
            rx_sh_q <= {vote, rx_sh_q[8:1]};
            if ((rx_bits_q == ((mode == 2'd1) ? 4'd10 : 4'd11)) && vote) rx_st_q <= RX_IDLE;
            if (last_uart) rx_st_q <= RX_IDLE;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // interrupt requests follow the flags
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      serial_irq <= 1'b0;
      timer2_irq <= 1'b0;
    end else begin
      serial_irq <= ctrl_q[`SPCBG_B_TX_DONE] | ctrl_q[`SPCBG_B_RX_DONE];
      timer2_irq <= t2_ctrl_q[`SPCBG_B_T2_EXF] | t2_ctrl_q[`SPCBG_B_T2_OVF];
    end
  end
endmodule

/* verification/spcbg_serial_port_monitor.sv */
// assertion checker for the serial port block
`timescale 1ns/10ps
module spcbg_port_checker (
  input logic        core_clk,   // clock
  input logic        rst,        // reset
  input logic        psel,       // apb select
  input logic        penable,    // apb enable
  input logic        pwrite,     // apb direction
  input logic [11:0] paddr,      // apb address
  input logic [31:0] pwdata,     // apb write data
  input logic [31:0] prdata,     // apb read data
  input logic        pready,     // apb ready
  input logic        pslverr,    // apb error
  input logic        rxd_oe_n,   // data pin enable
  input logic        serial_irq, // serial request
  input logic        timer2_irq  // timer2 request
);
  logic [1:0] mode_q; // mode last written
  wire acc = psel && penable;
  wire wr_ok = acc && pready && pwrite && !pslverr;
  wire rd_ok = acc && pready && !pwrite && !pslverr;
  wire m0_wr = wr_ok && paddr == 12'h004 && mode_q == 2'h0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // track mode bits from control writes
  always_ff @(posedge core_clk or posedge rst)
    if (rst) mode_q <= 2'h0;
    else if (wr_ok && paddr == 12'h000) mode_q <= pwdata[7:6];
  ready_wait_a: assert property (acc && !pready |=> pready) else $error("late ready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  ready_bus_a: assert property (pready |-> acc) else $error("ready without access");
  err_map_a: assert property (pready && paddr > 12'h018 |-> pslverr) else $error("no error");
  read_width_a: assert property (rd_ok && paddr < 12'h014 |-> prdata[31:8] == 24'h0)
    else $error("wide read");
  ovf_never_a: assert property (rd_ok && paddr == 12'h010 |-> !prdata[0])
    else $error("overflow flag set");
  serial_irq_a: assert property (rd_ok && paddr == 12'h000 && prdata[1:0] != 2'h0
    |-> ##[0:2] serial_irq) else $error("no serial request");
  ext_irq_a: assert property (rd_ok && paddr == 12'h010 && prdata[1]
    |-> ##[0:2] timer2_irq) else $error("no timer2 request");
  m0_gap_a: assert property (m0_wr |=> rxd_oe_n [*8]) else $error("shift too early");
  m0_start_a: assert property (m0_wr |-> ##[12:30] !rxd_oe_n) else $error("no shift");
  oe_mode0_a: assert property (!rxd_oe_n |-> mode_q == 2'h0) else $error("drive out of mode");
  cover property (m0_wr);
  cover property (rd_ok && paddr == 12'h000 && prdata[0]);
  cover property (timer2_irq);
endmodule
bind spcbg_serial_port spcbg_port_checker chk_u (.core_clk(core_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxd_oe_n(rxd_oe_n), .serial_irq(serial_irq),
  .timer2_irq(timer2_irq));

/* verification/spcbg_link_model.sv */
// remote serial device on the data and clock pins
`timescale 1ns/10ps
module spcbg_link_model (
  input  logic core_clk, // clock
  input  logic txd_out,  // uart line or shift clock
  input  logic rxd_out,  // shift data out
  input  logic rxd_oe_n, // shift drive, low
  output logic rxd_in    // line into block
);
  logic [7:0] m0_q;    // byte shifted in
  logic       tx_prev; // last shift clock
  initial rxd_in = 1'b1;
  // mode 0 capture on shift clock rise, lsb first
  always @(posedge core_clk) begin
    tx_prev <= txd_out;
    if (!rxd_oe_n && txd_out && !tx_prev) m0_q <= {rxd_out, m0_q[7:1]};
  end
  // send start, nb data bits lsb first, stop
  task automatic send(input logic [8:0] d, input int nb, input logic stp, input int bc);
    int n;
    for (n = 0; n < nb + 2; n++) begin
      rxd_in <= (n == 0) ? 1'b0 : (n <= nb) ? d[n-1] : stp;
      repeat (bc) @(posedge core_clk);
    end
    rxd_in <= 1'b1;
  endtask
  // take one frame off the line, sampling mid bit
  task automatic recv(input int nb, input int bc, output logic [8:0] d, output logic stp,
                      output logic ok);
    int n;
    d = 9'h000;
    for (n = 0; n < 8000 && txd_out; n++) @(posedge core_clk);
    ok = !txd_out;
    repeat (bc / 2) @(posedge core_clk);
    ok = ok && !txd_out;
    for (n = 0; n < nb; n++) begin
      repeat (bc) @(posedge core_clk);
      d[n] = txd_out;
    end
    repeat (bc) @(posedge core_clk);
    stp = txd_out;
  endtask
endmodule

/* verification/serial_port_control_and_baud_generation_test.sv */
// self-checking bench for the serial port block
`timescale 1ns/10ps
`include "spcbg_defs.vh"
module serial_port_control_and_baud_generation_test;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        t2pin = 1'b1;
  wire  [31:0] prdata;
  wire         pready, pslverr, rxd_out, rxd_oe_n, txd_out, serial_irq, timer2_irq, link_rxd;
  wire         rxd_line = rxd_oe_n ? link_rxd : rxd_out; // resolved data pin
  int          mismatches = 0;
  int          check_count = 0;
  logic [31:0] r;
  logic        err_q, stp, ok;
  logic [8:0]  d;
  logic [7:0]  tx_c [4] = '{8'h40, 8'h88, 8'h80, 8'hC8};
  logic        tx_s [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  logic        tx_t [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
  logic [7:0]  rx_c [5] = '{8'hB0, 8'hB0, 8'h70, 8'h50, 8'h40};
  logic        rx_9 [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  logic        rx_f [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  spcbg_serial_port dut_u (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd_in(rxd_line), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n),
    .txd_out(txd_out), .timer2_external_pin(t2pin), .serial_irq(serial_irq),
    .timer2_irq(timer2_irq));
  spcbg_link_model link_u (.core_clk(core_clk), .txd_out(txd_out), .rxd_out(rxd_out),
    .rxd_oe_n(rxd_oe_n), .rxd_in(link_rxd));
  // clock
  initial forever #2 core_clk = ~core_clk;
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    chk("pready", 1, pready);
    r = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, r);
  endtask
  // poll control until bit b sets, bounded
  task automatic wait_flag(input int b);
    for (int n = 0; n < 60; n++) begin
      apb(1'b0, `SPCBG_ADDR_CTRL, 32'h0);
      if (r[b] === 1'b1) break;
    end
  endtask
  // clocks per bit for a setting
  function automatic int bitclk(input logic [7:0] c, input logic sm, input logic t2);
    if (c[7:6] == 2'b10) return 64 >> sm;
    if (t2) return 32 * (65536 - 32'hFFFF);
    return (32 >> sm) * 12 * (256 - 32'hFF);
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (100000) @(posedge core_clk);
    mismatches++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    logic [7:0] b;
    int i;
    void'($urandom(32'hAD608317));
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rdchk(`SPCBG_ADDR_CTRL, 32'h0, "ctrl");
    rdchk(`SPCBG_ADDR_RATE, 32'h0, "rate");
    rdchk(12'h100, 32'h0, "unmapped");
    chk("slverr", 1, err_q);
    $display("test reset done");
    apb(1'b1, `SPCBG_ADDR_T2CTRL, 32'h0);
    apb(1'b1, `SPCBG_ADDR_T2RLD, 32'hFFFF);
    apb(1'b1, `SPCBG_ADDR_T2CNT, 32'hFFFF);
    apb(1'b1, `SPCBG_ADDR_T1RLD, 32'hFF);
    for (i = 0; i < 4; i++) begin
      b = 8'($urandom);
      apb(1'b1, `SPCBG_ADDR_T2CTRL, tx_t[i] ? 32'h34 : 32'h0);
      apb(1'b1, `SPCBG_ADDR_RATE, {31'h0, tx_s[i]});
      apb(1'b1, `SPCBG_ADDR_CTRL, {24'h0, tx_c[i]});
      apb(1'b1, `SPCBG_ADDR_BUF, {24'h0, b});
      link_u.recv(tx_c[i][7] ? 9 : 8, bitclk(tx_c[i], tx_s[i], tx_t[i]), d, stp, ok);
      chk("start", 1, ok);
      chk("tx data", b, d[7:0]);
      if (tx_c[i][7]) chk("tx ninth", tx_c[i][3], d[8]);
      chk("stop", 1, stp);
      wait_flag(1);
      chk("tx flag", 1, r[1]);
      chk("irq", 1, serial_irq);
      apb(1'b1, `SPCBG_ADDR_CTRL, {24'h0, tx_c[i]});
      @(posedge core_clk);
      chk("irq clear", 0, serial_irq);
    end
    $display("test transmit done");
    apb(1'b1, `SPCBG_ADDR_T2CTRL, 32'h34);
    for (i = 0; i < 5; i++) begin
      b = 8'($urandom);
      apb(1'b1, `SPCBG_ADDR_CTRL, {24'h0, rx_c[i]});
      link_u.send({rx_9[i], b}, rx_c[i][7] ? 9 : 8, rx_c[i][7] | rx_9[i],
                  bitclk(rx_c[i], 1'b1, 1'b1));
      wait_flag(0);
      chk("rx flag", rx_f[i], r[0]);
      if (rx_f[i]) begin
        chk("rx ninth", rx_9[i], r[2]);
        rdchk(`SPCBG_ADDR_BUF, b, "rx data");
      end
    end
    $display("test receive done");
    apb(1'b1, `SPCBG_ADDR_CTRL, 32'h0);
    b = 8'($urandom);
    apb(1'b1, `SPCBG_ADDR_BUF, {24'h0, b});
    wait_flag(1);
    chk("m0 tx flag", 1, r[1]);
    chk("m0 data", b, link_u.m0_q);
    apb(1'b1, `SPCBG_ADDR_CTRL, 32'h10);
    wait_flag(0);
    chk("m0 rx flag", 1, r[0]);
    rdchk(`SPCBG_ADDR_BUF, 32'hFF, "m0 rx data");
    $display("test shift mode done");
    apb(1'b1, `SPCBG_ADDR_T2CTRL, 32'h3C);
    t2pin <= 1'b0;
    for (i = 0; i < 20 && timer2_irq !== 1'b1; i++) @(posedge core_clk);
    chk("t2 irq", 1, timer2_irq);
    apb(1'b0, `SPCBG_ADDR_T2CTRL, 32'h0);
    chk("t2 flags", 32'h3E, r);
    $display("test timer2 done");
    tally_and_finish;
  end
endmodule
